// ==== ieregs_consts.svh ====
// Constants for the interrupt enable register pair
`ifndef IEREGS_CONSTS_SVH
`define IEREGS_CONSTS_SVH
// Register byte addresses (chosen)
`define IEREGS_ADDR_GRP3 12'h000
`define IEREGS_ADDR_GRP5 12'h004
`define IEREGS_ADDR_SRC 12'h008
`define IEREGS_ADDR_REQ 12'h00c
// Implemented bit positions, group three
`define IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT 13
`define IEREGS_BIT_LVD 8
`define IEREGS_BIT_CRC 3
`define IEREGS_BIT_U2ER 2
`define IEREGS_BIT_U1ER 1
// Implemented bit position, group five
`define IEREGS_BIT_OTG 6
// Writable masks; all other bits read zero
`define IEREGS_MASK_GRP3 16'h210e
`define IEREGS_MASK_GRP5 16'h0040
// Reset value of enables
`define IEREGS_RST_VAL 16'h0000
// Bytes per register word and widest APB address
`define IEREGS_WORD_BYTES 4
`define IEREGS_APB_ADDR_MAX_W 32
// Number of gated sources
`define IEREGS_SRC_COUNT 6
`endif

// ==== ieregs_pkg.sv ====
// Types for the interrupt enable register pair
package ieregs_pkg;
  // Per-source request vector, one bit each
  typedef struct packed {
    logic otg;
    logic charge_time_measurement_unit;
    logic lvd;
    logic crc;
    logic u2er;
    logic u1er;
  } ieregs_src_s;
endpackage : ieregs_pkg

// ==== ieregs_gate.sv ====
// One enable-and-flag gate
`timescale 1ns/1ps
module ieregs_gate (
  // Inputs
  input wire logic flag,
  input wire logic enable,
  // Output
  output logic req
);
  // Request only when flag and enable both high
  assign req = flag & enable;
endmodule : ieregs_gate

// ==== ieregs_top.sv ====
// Interrupt enable registers three and five with APB access
//
// Contract
// - Register three holds enables for the charge-time unit at bit 13 and low-voltage detect at bit 8.
// - Register three holds enables for the checksum generator at bit 3 and serial errors at bits 2 and 1.
// - Register five holds the on-the-go module enable at bit 6.
// - A stored one allows its source request and a stored zero blocks it.
// - Unimplemented bits read zero and ignore writes.
// - All enable bits are zero after reset.
`timescale 1ns/1ps
`include "ieregs_consts.svh"
module ieregs_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source flags and gated requests
  input wire ieregs_pkg::ieregs_src_s src_flag,
  output ieregs_pkg::ieregs_src_s src_req
);
  // Narrowest address that still tells the four words apart
  localparam int MIN_ADDR_W = $clog2(`IEREGS_ADDR_REQ + `IEREGS_WORD_BYTES);
  // Number of gated sources, taken from the carrier struct
  localparam int SRC_N = $bits(ieregs_pkg::ieregs_src_s);

  // Refuse an address width the decode cannot serve
  if (ADDR_W < MIN_ADDR_W) begin : g_chk_addr_min
    $error("ADDR_W too narrow for the register words");
  end
  if (ADDR_W > `IEREGS_APB_ADDR_MAX_W) begin : g_chk_addr_max
    $error("ADDR_W wider than an APB address");
  end
  // Refuse a source struct that no longer matches the gates
  if (SRC_N != `IEREGS_SRC_COUNT) begin : g_chk_src_n
    $error("source struct does not hold six sources");
  end
  // Refuse masks that disagree with the bit positions
  if (`IEREGS_MASK_GRP3 != ((16'h0001 << `IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT) | (16'h0001 << `IEREGS_BIT_LVD) |
                            (16'h0001 << `IEREGS_BIT_CRC) | (16'h0001 << `IEREGS_BIT_U2ER) |
                            (16'h0001 << `IEREGS_BIT_U1ER))) begin : g_chk_mask3
    $error("group three mask disagrees with its bit positions");
  end
  if (`IEREGS_MASK_GRP5 != (16'h0001 << `IEREGS_BIT_OTG)) begin : g_chk_mask5
    $error("group five mask disagrees with its bit position");
  end

  // Stored enables, one word per group
  logic [15:0] irq_enable_group_three;
  logic [15:0] irq_enable_group_five;
  // Enables in source order
  ieregs_pkg::ieregs_src_s en_vec;
  // Bus decode and read path
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [31:0] next_prdata;

  // Access decode; single-cycle access phase
  assign pready = 1'b1;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign addr_ok = (paddr[ADDR_W-1:0] == ADDR_W'(`IEREGS_ADDR_GRP3)) ||
                   (paddr[ADDR_W-1:0] == ADDR_W'(`IEREGS_ADDR_GRP5)) ||
                   (paddr[ADDR_W-1:0] == ADDR_W'(`IEREGS_ADDR_SRC)) ||
                   (paddr[ADDR_W-1:0] == ADDR_W'(`IEREGS_ADDR_REQ));
  assign pslverr = psel & penable & ~addr_ok;

  // Byte strobes on low 16 bits
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wval = pwdata[15:0];

  // Enable register three
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_enable_group_three <= `IEREGS_RST_VAL;
    end else if (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3)) begin
      irq_enable_group_three <= ((irq_enable_group_three & ~wmask) | (wval & wmask))
                                & `IEREGS_MASK_GRP3;
    end
  end

  // Enable register five
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_enable_group_five <= `IEREGS_RST_VAL;
    end else if (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP5)) begin
      irq_enable_group_five <= ((irq_enable_group_five & ~wmask) | (wval & wmask))
                               & `IEREGS_MASK_GRP5;
    end
  end

  // Enables gathered per source
  assign en_vec.charge_time_measurement_unit = irq_enable_group_three[`IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT];
  assign en_vec.lvd = irq_enable_group_three[`IEREGS_BIT_LVD];
  assign en_vec.crc = irq_enable_group_three[`IEREGS_BIT_CRC];
  assign en_vec.u2er = irq_enable_group_three[`IEREGS_BIT_U2ER];
  assign en_vec.u1er = irq_enable_group_three[`IEREGS_BIT_U1ER];
  assign en_vec.otg = irq_enable_group_five[`IEREGS_BIT_OTG];

  // Gate each source
  for (genvar i = 0; i < SRC_N; i++) begin : g_gate
    ieregs_gate u_gate (
      .flag(src_flag[i]),
      .enable(en_vec[i]),
      .req(src_req[i])
    );
  end

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (paddr == ADDR_W'(`IEREGS_ADDR_GRP3)) begin
      next_prdata = {16'h0000, irq_enable_group_three};
    end else if (paddr == ADDR_W'(`IEREGS_ADDR_GRP5)) begin
      next_prdata = {16'h0000, irq_enable_group_five};
    end else if (paddr == ADDR_W'(`IEREGS_ADDR_SRC)) begin
      next_prdata = {26'h0000000, src_flag};
    end else if (paddr == ADDR_W'(`IEREGS_ADDR_REQ)) begin
      next_prdata = {26'h0000000, src_req};
    end
  end

  // Read data registered during setup phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Checks
  // Unimplemented group three bits stay clear
  property p_unimpl3;
    @(posedge core_clk) disable iff (sys_rst)
    (irq_enable_group_three & ~`IEREGS_MASK_GRP3) == 16'h0000;
  endproperty
  a_unimpl3: assert property (p_unimpl3) else $error("group three unimplemented bit set");

  // Unimplemented group five bits stay clear
  property p_unimpl5;
    @(posedge core_clk) disable iff (sys_rst)
    (irq_enable_group_five & ~`IEREGS_MASK_GRP5) == 16'h0000;
  endproperty
  a_unimpl5: assert property (p_unimpl5) else $error("group five unimplemented bit set");

  // Reset leaves every enable clear
  property p_reset_zero;
    @(posedge core_clk)
    sys_rst |=> (irq_enable_group_three == 16'h0000 && irq_enable_group_five == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("enables not cleared by reset");

  // Charge-time enable follows the high byte lane
  property p_charge_time_measurement_unit_wr;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3) && pstrb[1])
      |=> irq_enable_group_three[`IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT] == $past(pwdata[`IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT]);
  endproperty
  a_charge_time_measurement_unit_wr: assert property (p_charge_time_measurement_unit_wr) else $error("charge-time enable write lost");

  // Low group three enables follow the low byte lane
  property p_crc_wr;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3) && pstrb[0])
      |=> irq_enable_group_three[`IEREGS_BIT_CRC:`IEREGS_BIT_U1ER] == $past(pwdata[`IEREGS_BIT_CRC:`IEREGS_BIT_U1ER]);
  endproperty
  a_crc_wr: assert property (p_crc_wr) else $error("group three low enable write lost");

  // On-the-go enable follows the low byte lane
  property p_otg_wr;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP5) && pstrb[0])
      |=> irq_enable_group_five[`IEREGS_BIT_OTG] == $past(pwdata[`IEREGS_BIT_OTG]);
  endproperty
  a_otg_wr: assert property (p_otg_wr) else $error("otg enable write lost");

  // Clear on-the-go enable blocks its request
  property p_block;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_five[`IEREGS_BIT_OTG] |-> !src_req.otg;
  endproperty
  a_block: assert property (p_block) else $error("disabled otg request passed");

  // Every request is flag and enable
  property p_and;
    @(posedge core_clk) disable iff (sys_rst)
    src_req == (src_flag & en_vec);
  endproperty
  a_and: assert property (p_and) else $error("request not flag and enable");

  // Enables change only on a write
  property p_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !wr_acc |=> $stable(irq_enable_group_three) && $stable(irq_enable_group_five);
  endproperty
  a_hold: assert property (p_hold) else $error("enable changed without write");

  // Low-voltage enable follows the high byte lane
  property p_lvd_wr;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3) && pstrb[1])
      |=> irq_enable_group_three[`IEREGS_BIT_LVD] == $past(pwdata[`IEREGS_BIT_LVD]);
  endproperty
  a_lvd_wr: assert property (p_lvd_wr) else $error("low-voltage enable write lost");

  // High lane kept when its strobe is low
  property p_keep_hi;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3) && !pstrb[1])
      |=> $stable(irq_enable_group_three[`IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT:`IEREGS_BIT_LVD]);
  endproperty
  a_keep_hi: assert property (p_keep_hi) else $error("group three high lane changed without strobe");

  // Low lane kept when its strobe is low
  property p_keep_lo;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3) && !pstrb[0])
      |=> $stable(irq_enable_group_three[`IEREGS_BIT_CRC:`IEREGS_BIT_U1ER]);
  endproperty
  a_keep_lo: assert property (p_keep_lo) else $error("group three low lane changed without strobe");

  // Writes elsewhere leave both groups alone
  property p_other_keep;
    @(posedge core_clk) disable iff (sys_rst)
    (wr_acc && paddr != ADDR_W'(`IEREGS_ADDR_GRP3) && paddr != ADDR_W'(`IEREGS_ADDR_GRP5))
      |=> $stable(irq_enable_group_three) && $stable(irq_enable_group_five);
  endproperty
  a_other_keep: assert property (p_other_keep) else $error("enable changed by a foreign write");

  // Error only in the access phase of a foreign address
  property p_err_access;
    @(posedge core_clk) disable iff (sys_rst)
    pslverr |-> (psel && penable && !addr_ok);
  endproperty
  a_err_access: assert property (p_err_access) else $error("error outside a refused access");

  // Upper read half always zero
  property p_rd_upper;
    @(posedge core_clk) disable iff (sys_rst)
    rd_acc |-> prdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read half not zero");

  // Group three read returns the stored word
  property p_rd_grp3;
    @(posedge core_clk) disable iff (sys_rst)
    (rd_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3))
      |-> prdata == {16'h0000, irq_enable_group_three};
  endproperty
  a_rd_grp3: assert property (p_rd_grp3) else $error("group three read data wrong");

  // Group five read returns the stored word
  property p_rd_grp5;
    @(posedge core_clk) disable iff (sys_rst)
    (rd_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP5))
      |-> prdata == {16'h0000, irq_enable_group_five};
  endproperty
  a_rd_grp5: assert property (p_rd_grp5) else $error("group five read data wrong");

  // Reset blocks every request
  property p_reset_req;
    @(posedge core_clk)
    sys_rst |=> src_req == '0;
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("request passed after reset");

  // A clear enable blocks its own source
  property p_block_charge_time_measurement_unit;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_three[`IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT] |-> !src_req.charge_time_measurement_unit;
  endproperty
  a_block_charge_time_measurement_unit: assert property (p_block_charge_time_measurement_unit) else $error("disabled charge-time request passed");
  property p_block_lvd;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_three[`IEREGS_BIT_LVD] |-> !src_req.lvd;
  endproperty
  a_block_lvd: assert property (p_block_lvd) else $error("disabled low-voltage request passed");
  property p_block_crc;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_three[`IEREGS_BIT_CRC] |-> !src_req.crc;
  endproperty
  a_block_crc: assert property (p_block_crc) else $error("disabled checksum request passed");
  property p_block_u2er;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_three[`IEREGS_BIT_U2ER] |-> !src_req.u2er;
  endproperty
  a_block_u2er: assert property (p_block_u2er) else $error("disabled serial two request passed");
  property p_block_u1er;
    @(posedge core_clk) disable iff (sys_rst)
    !irq_enable_group_three[`IEREGS_BIT_U1ER] |-> !src_req.u1er;
  endproperty
  a_block_u1er: assert property (p_block_u1er) else $error("disabled serial one request passed");

  // Main scenarios
  c_wr3: cover property (@(posedge core_clk) wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP3));
  c_wr5: cover property (@(posedge core_clk) wr_acc && paddr == ADDR_W'(`IEREGS_ADDR_GRP5));
  c_req: cover property (@(posedge core_clk) src_req.charge_time_measurement_unit);
  c_err: cover property (@(posedge core_clk) pslverr);
  c_strobe: cover property (@(posedge core_clk) wr_acc && pstrb != 4'hf);
endmodule : ieregs_top

// ==== tb_ieregs_top.sv ====
// Self-checking testbench for the interrupt enable register pair
`timescale 1ns/1ps
`include "ieregs_consts.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_ieregs_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ieregs_pkg::ieregs_src_s src_flag = '0;
  ieregs_pkg::ieregs_src_s src_req;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  // Register and bit of each source, in request vector order
  logic [11:0] src_addr [6] = '{`IEREGS_ADDR_GRP3, `IEREGS_ADDR_GRP3, `IEREGS_ADDR_GRP3,
                                `IEREGS_ADDR_GRP3, `IEREGS_ADDR_GRP3, `IEREGS_ADDR_GRP5};
  int src_bit [6] = '{`IEREGS_BIT_U1ER, `IEREGS_BIT_U2ER, `IEREGS_BIT_CRC, `IEREGS_BIT_LVD,
                      `IEREGS_BIT_CHARGE_TIME_MEASUREMENT_UNIT, `IEREGS_BIT_OTG};

  ieregs_top #(.ADDR_W(12)) i_ieregs_top (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_flag(src_flag), .src_req(src_req));

  // Clock generation
  always #2.5 core_clk = ~core_clk;

  // Verdict and end of run
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end

  // One APB transfer, held until pready is seen
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    src_flag <= '1;
    apb(1'b0, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, `IEREGS_ADDR_GRP5, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0000)
    `CHK(src_req, 6'h00)
    apb(1'b1, `IEREGS_ADDR_GRP3, 32'hffff_ffff, rd, err);
    apb(1'b0, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
    `CHK(rd, 32'h0000_210e)
    apb(1'b1, `IEREGS_ADDR_GRP5, 32'hffff_ffff, rd, err);
    apb(1'b0, `IEREGS_ADDR_GRP5, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0040)
    @(negedge core_clk);
    `CHK(src_req, 6'h3f)
    @(posedge core_clk);
    src_flag <= 6'h15;
    @(negedge core_clk);
    `CHK(src_req, 6'h15)
    apb(1'b0, `IEREGS_ADDR_SRC, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0015)
    apb(1'b0, `IEREGS_ADDR_REQ, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0015)
    apb(1'b1, `IEREGS_ADDR_SRC, 32'hffff_ffff, rd, err);
    `CHK(err, 1'b0)
    src_flag <= '1;
    // Unmapped access is refused and leaves the group three enables alone
    apb(1'b1, 12'h010, 32'h0000_0000, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
    `CHK(rd, 32'h0000_210e)
    // High lane cleared alone, low lane kept
    pstrb <= 4'h2;
    apb(1'b1, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
    pstrb <= 4'hf;
    apb(1'b0, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
    `CHK(rd, 32'h0000_000e)
    // Mid-run reset clears every enable
    @(posedge core_clk);
    sys_rst <= 1'b1;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `IEREGS_ADDR_GRP5, 32'h0, rd, err);
    `CHK(rd, 32'h0000_0000)
    `CHK(src_req, 6'h00)
    // One source at a time
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `IEREGS_ADDR_GRP3, 32'h0, rd, err);
      apb(1'b1, src_addr[i], 32'(1 << src_bit[i]), rd, err);
      apb(1'b0, src_addr[i], 32'h0, rd, err);
      `CHK(rd, 32'(1 << src_bit[i]))
      @(negedge core_clk);
      `CHK(src_req, 6'(1 << i))
      apb(1'b1, src_addr[i], 32'h0, rd, err);
    end
    end_sim();
  end
endmodule : tb_ieregs_top
